// File: rtl/cgl_clock_ctrl_unit.sv
// Clock control unit: master clock source switch, derived clock enables, Idle and Sleep.
// Assumes source clocks arrive as levels synchronous to core_clk, well below its rate.
//
// Contract
// - Master clock from one of three sources, switched by firmware without glitches.
// - Separately divided and gated clocks for CPU, buses, flash, memory bus, baud, USB; the CPU enable here is the undivided master tick.
// - PLL uses the oscillator as reference, master clock at most 96 MHz.
// - Oscillator after power-up; PLL selectable only once it reports lock.
// - Oscillator reselectable any time, then PLL may be disabled.
// - PLL forced off on Sleep entry.
// - RTC clock selectable as slow master clock.
// - Flash clock from root clock, equal by default, optional halving, at most 96 MHz.
// - Baud and serial clock from master clock, optional halving.
// - Memory bus clock from system bus clock, same or half, optionally on a pin.
// - USB clock 48 MHz from master 48, master 96 halved, or external pin.
// - Oscillator forwarded to PHY clock pin when enabled; needs 25 MHz oscillator.
// - RTC clock optionally on debug return pin, running through Sleep.
// - Idle stops CPU and flash clocks at once; peripherals keep masks from before entry.
// - Idle left on any reset, any interrupt, or wake-up input.
// - Sleep stops every clock but RTC and disables the oscillator pins.
// - Sleep left on non-watchdog reset, RTC alarm or wake-up, with RTC running.
`include "cgl_map.svh"
`timescale 1ns/1ps
`default_nettype none

module cgl_clock_ctrl_unit #(
    parameter int WAKE_CYC = `CGL_OSC_SETTLE_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic oscClkIn,
    input wire logic pllClkIn,
    input wire logic rtcClkIn,
    input wire logic pllLocked,
    input wire logic [1:0] srcSel,
    input wire logic pllEnCfg,
    input wire logic fmiDiv2,
    input wire logic ahbDiv2,
    input wire logic apbDiv2,
    input wire logic bclkDiv2,
    input wire logic bclkPinEnCfg,
    input wire logic baudDiv2,
    input wire logic [1:0] usbSel,
    input wire logic usbExtClkIn,
    input wire logic phyClkEnCfg,
    input wire logic rtcOutEnCfg,
    input wire logic [`CGL_MASK_W-1:0] clkMask,
    input wire logic idleSet,
    input wire logic sleepSet,
    input wire logic irqPending,
    input wire logic rtcAlarm,
    input wire logic wakeupIn,
    input wire logic extResetEvt,
    input wire logic wdogResetEvt,
    input wire logic rtcRunning,
    output logic mstrClk,
    output logic [1:0] curSrc,
    output logic pllEnable,
    output logic oscPinEn,
    output logic cpuClkEn,
    output logic hclkEn,
    output logic pclkEn,
    output logic fmiClkEn,
    output logic bclkEn,
    output logic bclkPinOut,
    output logic baudClkEn,
    output logic usbClkEn,
    output logic phyClkOut,
    output logic debugRtcClkOut,
    output logic inIdle,
    output logic inSleep
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic srcLevel(input logic [1:0] sel, input logic [2:0] lv);
        srcLevel = (sel == `CGL_SRC_PLL) ? lv[1] : (sel == `CGL_SRC_RTC) ? lv[2] : lv[0];
    endfunction

    function automatic logic [2:0] srcOneHot(input logic [1:0] sel);
        srcOneHot = (sel == `CGL_SRC_PLL) ? 3'h2 : (sel == `CGL_SRC_RTC) ? 3'h4 : 3'h1;
    endfunction

    // Divide-by-one or by-two enable from a parent tick
    function automatic logic halfTick(input logic tick, input logic div2, input logic ph);
        halfTick = tick & (~div2 | ph);
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    localparam int CW = $clog2(WAKE_CYC + 1);
    localparam logic [CW-1:0] WAKE_LAST = CW'(WAKE_CYC - 1);

    cgl_pkg::cgl_mode_t mode_reg, mode_next;
    cgl_pkg::cgl_sw_t sw_reg, sw_next;
    logic [1:0] cur_reg, cur_next, tgt_reg, tgt_next;
    logic [2:0] gate_reg, gate_next;
    logic mstr_reg, mstr_next, mstrPrev_reg;
    logic pllEn_reg, pllEn_next, pllCfgPrev_reg;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic [`CGL_MASK_W-1:0] mask_reg, mask_next;
    logic hPh_reg, pPh_reg, fPh_reg, bPh_reg, brPh_reg, uPh_reg, usbPrev_reg;
    logic bPin_reg, bPin_next;
    logic [1:0] want;
    logic [2:0] lv;
    logic mstrTick, hTick, pTick, fTick, bTick, brTick, uTick;
    logic [6:0] en_next, en_reg;
    logic phy_reg, rtcOut_reg;

    assign lv = {rtcClkIn, pllClkIn, oscClkIn};

    // ----------------------------------------
    // Source selection and glitch-free switch
    // ----------------------------------------
    always_comb begin
        want = `CGL_SRC_OSC;
        if (mode_reg == cgl_pkg::CGL_RUN || mode_reg == cgl_pkg::CGL_IDLE) begin
            case (srcSel)
                `CGL_SRC_PLL: begin
                    // Unlocked PLL request is ignored; a PLL losing lock falls back
                    if (pllLocked && pllEn_reg) begin
                        want = `CGL_SRC_PLL;
                    end else if (cur_reg == `CGL_SRC_PLL) begin
                        want = `CGL_SRC_OSC;
                    end else begin
                        want = cur_reg;
                    end
                end
                `CGL_SRC_RTC: want = `CGL_SRC_RTC;
                default: want = `CGL_SRC_OSC;
            endcase
        end
        sw_next = sw_reg;
        cur_next = cur_reg;
        tgt_next = tgt_reg;
        gate_next = gate_reg;
        case (sw_reg)
            cgl_pkg::CGL_SW_STEADY: begin
                if (want != cur_reg) begin
                    tgt_next = want;
                    sw_next = cgl_pkg::CGL_SW_DROP;
                end
            end
            cgl_pkg::CGL_SW_DROP: begin
                if (!srcLevel(cur_reg, lv)) begin
                    gate_next = 3'h0;
                    sw_next = cgl_pkg::CGL_SW_RAISE;
                end
            end
            cgl_pkg::CGL_SW_RAISE: begin
                if (!srcLevel(tgt_reg, lv)) begin
                    gate_next = srcOneHot(tgt_reg);
                    cur_next = tgt_reg;
                    sw_next = cgl_pkg::CGL_SW_STEADY;
                end
            end
            default: sw_next = cgl_pkg::CGL_SW_STEADY;
        endcase
        // Gates only move while their source is low, so no runt pulse
        mstr_next = |(lv & gate_reg);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sw_reg <= cgl_pkg::CGL_SW_STEADY;
            cur_reg <= `CGL_SRC_OSC;
            tgt_reg <= `CGL_SRC_OSC;
            gate_reg <= 3'h1;
            mstr_reg <= 1'b0;
            mstrPrev_reg <= 1'b0;
        end else begin
            sw_reg <= sw_next;
            cur_reg <= cur_next;
            tgt_reg <= tgt_next;
            gate_reg <= gate_next;
            mstr_reg <= mstr_next;
            mstrPrev_reg <= mstr_reg;
        end
    end

    // ----------------------------------------
    // Power modes and PLL enable
    // ----------------------------------------
    always_comb begin
        mode_next = mode_reg;
        cnt_next = cnt_reg;
        pllEn_next = pllEn_reg;
        if (!pllEnCfg) begin
            pllEn_next = 1'b0;
        end else if (!pllCfgPrev_reg && mode_reg == cgl_pkg::CGL_RUN) begin
            pllEn_next = 1'b1;
        end
        // Masks are held frozen while away from Run
        mask_next = (mode_reg == cgl_pkg::CGL_RUN) ? clkMask : mask_reg;
        case (mode_reg)
            cgl_pkg::CGL_RUN: begin
                if (sleepSet) begin
                    mode_next = cgl_pkg::CGL_SLEEP;
                    pllEn_next = 1'b0;
                end else if (idleSet) begin
                    mode_next = cgl_pkg::CGL_IDLE;
                end
            end
            cgl_pkg::CGL_IDLE: begin
                if (extResetEvt || wdogResetEvt || irqPending || rtcAlarm || wakeupIn) begin
                    mode_next = cgl_pkg::CGL_RUN;
                end
            end
            cgl_pkg::CGL_SLEEP: begin
                pllEn_next = 1'b0;
                // Watchdog cannot wake a stopped chip
                if (rtcRunning && (extResetEvt || rtcAlarm || wakeupIn)) begin
                    mode_next = cgl_pkg::CGL_WAKE;
                    cnt_next = '0;
                end
            end
            cgl_pkg::CGL_WAKE: begin
                pllEn_next = 1'b0;
                if (cnt_reg != WAKE_LAST) begin
                    cnt_next = cnt_reg + CW'(1);
                end else if (sw_reg == cgl_pkg::CGL_SW_STEADY && cur_reg == `CGL_SRC_OSC) begin
                    mode_next = cgl_pkg::CGL_RUN;
                end
            end
            default: mode_next = cgl_pkg::CGL_RUN;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode_reg <= cgl_pkg::CGL_RUN;
            cnt_reg <= '0;
            pllEn_reg <= 1'b0;
            pllCfgPrev_reg <= 1'b0;
            mask_reg <= '0;
        end else begin
            mode_reg <= mode_next;
            cnt_reg <= cnt_next;
            pllEn_reg <= pllEn_next;
            pllCfgPrev_reg <= pllEnCfg;
            mask_reg <= mask_next;
        end
    end

    // ----------------------------------------
    // Derived clock enables
    // ----------------------------------------
    always_comb begin
        mstrTick = mstr_reg & ~mstrPrev_reg;
        hTick = halfTick(mstrTick, ahbDiv2, hPh_reg);
        pTick = halfTick(hTick, apbDiv2, pPh_reg);
        // Flash rate limit is firmware's job: halve when root runs above 96 MHz
        fTick = halfTick(mstrTick, fmiDiv2, fPh_reg);
        bTick = halfTick(hTick, bclkDiv2, bPh_reg);
        brTick = halfTick(mstrTick, baudDiv2, brPh_reg);
        case (usbSel)
            `CGL_USB_MSTR48: uTick = mstrTick;
            `CGL_USB_MSTR96: uTick = halfTick(mstrTick, 1'b1, uPh_reg);
            `CGL_USB_EXT: uTick = usbExtClkIn & ~usbPrev_reg;
            default: uTick = 1'b0;
        endcase
        en_next = '0;
        bPin_next = bPin_reg;
        case (mode_reg)
            cgl_pkg::CGL_RUN: begin
                en_next[0] = mstrTick;
                en_next[3] = fTick;
                en_next[1] = hTick & clkMask[`CGL_MASK_HCLK];
                en_next[2] = pTick & clkMask[`CGL_MASK_PCLK];
                en_next[4] = bTick & clkMask[`CGL_MASK_BCLK];
                en_next[5] = brTick & clkMask[`CGL_MASK_BAUD];
                en_next[6] = uTick & clkMask[`CGL_MASK_USB];
            end
            cgl_pkg::CGL_IDLE: begin
                en_next[1] = hTick & mask_reg[`CGL_MASK_HCLK];
                en_next[2] = pTick & mask_reg[`CGL_MASK_PCLK];
                en_next[4] = bTick & mask_reg[`CGL_MASK_BCLK];
                en_next[5] = brTick & mask_reg[`CGL_MASK_BAUD];
                en_next[6] = uTick & mask_reg[`CGL_MASK_USB];
            end
            default: en_next = '0;
        endcase
        if (en_next[4] && bclkPinEnCfg) begin
            bPin_next = ~bPin_reg;
        end else if (!bclkPinEnCfg) begin
            bPin_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hPh_reg <= 1'b0;
            pPh_reg <= 1'b0;
            fPh_reg <= 1'b0;
            bPh_reg <= 1'b0;
            brPh_reg <= 1'b0;
            uPh_reg <= 1'b0;
            usbPrev_reg <= 1'b0;
            en_reg <= '0;
            bPin_reg <= 1'b0;
            phy_reg <= 1'b0;
            rtcOut_reg <= 1'b0;
        end else begin
            hPh_reg <= mstrTick ? ~hPh_reg : hPh_reg;
            pPh_reg <= hTick ? ~pPh_reg : pPh_reg;
            fPh_reg <= mstrTick ? ~fPh_reg : fPh_reg;
            bPh_reg <= hTick ? ~bPh_reg : bPh_reg;
            brPh_reg <= mstrTick ? ~brPh_reg : brPh_reg;
            uPh_reg <= mstrTick ? ~uPh_reg : uPh_reg;
            usbPrev_reg <= usbExtClkIn;
            en_reg <= en_next;
            bPin_reg <= bPin_next;
            // Only a 25 MHz oscillator gives a usable PHY clock
            phy_reg <= phyClkEnCfg & oscClkIn & ~inSleep;
            rtcOut_reg <= rtcOutEnCfg & rtcClkIn;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign mstrClk = mstr_reg;
    assign curSrc = cur_reg;
    // Reference is the oscillator; output ceiling of 96 MHz is set by PLL programming
    assign pllEnable = pllEn_reg;
    assign oscPinEn = (mode_reg != cgl_pkg::CGL_SLEEP);
    assign cpuClkEn = en_reg[0];
    assign hclkEn = en_reg[1];
    assign pclkEn = en_reg[2];
    assign fmiClkEn = en_reg[3];
    assign bclkEn = en_reg[4];
    assign bclkPinOut = bPin_reg;
    assign baudClkEn = en_reg[5];
    assign usbClkEn = en_reg[6];
    assign phyClkOut = phy_reg;
    assign debugRtcClkOut = rtcOut_reg;
    assign inIdle = (mode_reg == cgl_pkg::CGL_IDLE);
    assign inSleep = (mode_reg == cgl_pkg::CGL_SLEEP);

endmodule

`default_nettype wire

// File: rtl/cgl_map.svh
// Constants for the clock control unit: source codes, field positions, timing counts.
// Assumes a 200 MHz core clock; included by its bare name.
`ifndef CGL_MAP_SVH
`define CGL_MAP_SVH

// ----------------------------------------
// Master clock source codes
// ----------------------------------------
`define CGL_SRC_OSC 2'h0
`define CGL_SRC_PLL 2'h1
`define CGL_SRC_RTC 2'h2

// ----------------------------------------
// USB clock source codes
// ----------------------------------------
`define CGL_USB_MSTR48 2'h0
`define CGL_USB_MSTR96 2'h1
`define CGL_USB_EXT 2'h2

// ----------------------------------------
// Peripheral clock mask bit positions
// ----------------------------------------
`define CGL_MASK_HCLK 0
`define CGL_MASK_PCLK 1
`define CGL_MASK_BCLK 2
`define CGL_MASK_BAUD 3
`define CGL_MASK_USB 4
`define CGL_MASK_W 5

// ----------------------------------------
// Timing
// ----------------------------------------
`define CGL_CLK_PERIOD_PS 5000
`define CGL_OSC_SETTLE_NS 2000
`define CGL_OSC_SETTLE_CYC \
    ((`CGL_OSC_SETTLE_NS * 1000 + `CGL_CLK_PERIOD_PS - 1) / `CGL_CLK_PERIOD_PS)

`endif

// File: rtl/cgl_pkg.sv
// Types for the clock control unit.
// Assumes nothing beyond a SystemVerilog compiler.
package cgl_pkg;

    // ----------------------------------------
    // Power modes
    // ----------------------------------------
    typedef enum logic [3:0] {
        CGL_RUN = 4'h1,
        CGL_IDLE = 4'h2,
        CGL_SLEEP = 4'h4,
        CGL_WAKE = 4'h8
    } cgl_mode_t;

    // ----------------------------------------
    // Source switch sequence
    // ----------------------------------------
    typedef enum logic [2:0] {
        CGL_SW_STEADY = 3'h1,
        CGL_SW_DROP = 3'h2,
        CGL_SW_RAISE = 3'h4
    } cgl_sw_t;

endpackage

// File: tb/cgl_src_model.sv
// Source clock model: oscillator, PLL, RTC and external USB clock levels.
// Assumes the unit samples these on core_clk; periods are in core_clk cycles.
`timescale 1ns/1ps
`default_nettype none
module cgl_src_model #(
    parameter int LOCK_CYC = 24
) (
    input wire logic core_clk,
    input wire logic pllEnable,
    input wire logic oscPinEn,
    output logic oscClk,
    output logic pllClk,
    output logic rtcClk,
    output logic usbExtClk,
    output logic pllLocked
);
    int t = 0;
    int lockCnt = 0;
    always @(posedge core_clk) begin
        t <= t + 1;
        // Crystal stands low once its pins are disabled
        oscClk <= oscPinEn && t % 8 < 4;
        rtcClk <= t % 20 < 10;
        usbExtClk <= t % 6 < 3;
        // PLL runs off the oscillator, so it dies with it
        pllClk <= pllEnable && oscPinEn && t % 4 < 2;
        lockCnt <= (pllEnable && oscPinEn) ? lockCnt + 1 : 0;
        pllLocked <= lockCnt >= LOCK_CYC;
    end
endmodule
`default_nettype wire

// File: tb/cgl_clock_ctrl_unit_chk.sv
// Checker for the clock control unit: mode, source and gating relations.
// Assumes it is bound to the unit's top module; one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "cgl_map.svh"
module cgl_clock_ctrl_unit_chk (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic rtcClkIn,
    input wire logic rtcOutEnCfg,
    input wire logic oscClkIn,
    input wire logic phyClkEnCfg,
    input wire logic phyClkOut,
    input wire logic pllLocked,
    input wire logic irqPending,
    input wire logic rtcAlarm,
    input wire logic wakeupIn,
    input wire logic extResetEvt,
    input wire logic wdogResetEvt,
    input wire logic rtcRunning,
    input wire logic mstrClk,
    input wire logic [1:0] curSrc,
    input wire logic pllEnable,
    input wire logic oscPinEn,
    input wire logic cpuClkEn,
    input wire logic hclkEn,
    input wire logic fmiClkEn,
    input wire logic usbClkEn,
    input wire logic debugRtcClkOut,
    input wire logic inIdle,
    input wire logic inSleep
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sleep_pll_off_a: assert property (inSleep |-> !pllEnable)
        else $error("pll enabled in sleep");
    sleep_quiet_a: assert property (inSleep && $past(inSleep) |->
        !(cpuClkEn || hclkEn || fmiClkEn || usbClkEn || oscPinEn))
        else $error("clock running in sleep");
    idle_cpu_off_a: assert property (inIdle && $past(inIdle) |->
        !cpuClkEn && !fmiClkEn)
        else $error("cpu or flash clock in idle");
    pll_locked_a: assert property ($changed(curSrc) && curSrc == `CGL_SRC_PLL |->
        $past(pllLocked && pllEnable))
        else $error("pll taken without lock");
    switch_low_a: assert property ($changed(curSrc) |-> !mstrClk && !$past(mstrClk))
        else $error("master clock high across switch");
    rtc_out_a: assert property ($past(rst_n) |->
        debugRtcClkOut == $past(rtcClkIn && rtcOutEnCfg))
        else $error("rtc output wrong");
    phy_out_a: assert property ($past(rst_n) |->
        phyClkOut == $past(phyClkEnCfg && oscClkIn && !inSleep))
        else $error("phy clock output wrong");
    sleep_hold_a: assert property (
        inSleep && !(rtcRunning && (extResetEvt || rtcAlarm || wakeupIn)) |=> inSleep)
        else $error("sleep left without cause");
    sleep_exit_a: assert property (
        inSleep && rtcRunning && (extResetEvt || rtcAlarm || wakeupIn) |=> !inSleep && !inIdle)
        else $error("sleep not left");
    idle_exit_a: assert property (inIdle &&
        (irqPending || rtcAlarm || wakeupIn || extResetEvt || wdogResetEvt) |=> !inIdle && !inSleep)
        else $error("idle not left");
    wake_settle_a: assert property ($fell(inSleep) |-> (!cpuClkEn && !pllEnable) [*3])
        else $error("cpu clock or pll too early after sleep");
endmodule
`default_nettype wire

// File: tb/cgl_clock_ctrl_unit_tb_top.sv
// Testbench for the clock control unit: random settings and mode scenarios.
// Assumes the source model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "cgl_map.svh"
module cgl_clock_ctrl_unit_tb_top;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] srcSel = `CGL_SRC_OSC;
    logic [1:0] usbSel = 2'h0;
    logic [4:0] dv = 5'h00; // Halving: fmi, ahb, apb, bclk, baud
    logic [3:0] cf = 4'h0; // Enables: pll, bclk pin, phy, rtc out
    logic [4:0] mask = 5'h1f;
    logic [4:0] ev = 5'h00; // Irq, alarm, pin, ext reset, watchdog
    logic idleSet = 1'b0;
    logic sleepSet = 1'b0;
    logic rtcRunning = 1'b1;
    logic [31:0] seed = 32'h52;
    logic [11:0] prv = 12'h000;
    int cnt [12];
    int error_cnt = 0;
    int n_checks = 0;
    wire logic osc, pll, rtc, usbExt, pllLocked, mstrClk, pllEnable, oscPinEn, bclkPinOut;
    wire logic cpuClkEn, hclkEn, pclkEn, fmiClkEn, bclkEn, baudClkEn, usbClkEn;
    wire logic phyClkOut, debugRtcClkOut, inIdle, inSleep;
    wire logic [1:0] curSrc;
    wire logic [11:0] mon;

    cgl_src_model src_u (.core_clk(core_clk), .pllEnable(pllEnable), .oscPinEn(oscPinEn),
        .oscClk(osc), .pllClk(pll), .rtcClk(rtc), .usbExtClk(usbExt), .pllLocked(pllLocked));
    cgl_clock_ctrl_unit #(.WAKE_CYC(4)) dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .oscClkIn(osc), .pllClkIn(pll), .rtcClkIn(rtc),
        .pllLocked(pllLocked), .srcSel(srcSel), .pllEnCfg(cf[0]), .fmiDiv2(dv[0]),
        .ahbDiv2(dv[1]), .apbDiv2(dv[2]), .bclkDiv2(dv[3]), .bclkPinEnCfg(cf[1]),
        .baudDiv2(dv[4]), .usbSel(usbSel), .usbExtClkIn(usbExt), .phyClkEnCfg(cf[2]),
        .rtcOutEnCfg(cf[3]), .clkMask(mask), .idleSet(idleSet), .sleepSet(sleepSet),
        .irqPending(ev[0]), .rtcAlarm(ev[1]), .wakeupIn(ev[2]), .extResetEvt(ev[3]),
        .wdogResetEvt(ev[4]), .rtcRunning(rtcRunning), .mstrClk(mstrClk), .curSrc(curSrc),
        .pllEnable(pllEnable), .oscPinEn(oscPinEn), .cpuClkEn(cpuClkEn), .hclkEn(hclkEn),
        .pclkEn(pclkEn), .fmiClkEn(fmiClkEn), .bclkEn(bclkEn), .bclkPinOut(bclkPinOut),
        .baudClkEn(baudClkEn), .usbClkEn(usbClkEn), .phyClkOut(phyClkOut),
        .debugRtcClkOut(debugRtcClkOut), .inIdle(inIdle), .inSleep(inSleep));

    // ---
    // Monitors: pulses for enables, rising edges for clocks and pins
    // ---
    assign mon = {phyClkOut, debugRtcClkOut, usbExt, bclkPinOut, mstrClk, usbClkEn, baudClkEn,
        bclkEn, fmiClkEn, pclkEn, hclkEn, cpuClkEn};
    always #2.5 core_clk = ~core_clk;
    // Counted on the falling edge, where registered outputs have settled
    always @(negedge core_clk) begin
        for (int i = 0; i < 12; i++) begin
            if (mon[i] === 1'b1 && (i < 7 || prv[i] !== 1'b1)) begin
                cnt[i]++;
            end
        end
        prv <= mon;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int expc(int t, logic d, logic m);
        return m ? (d ? t / 2 : t) : 0;
    endfunction
    function automatic logic cond(int c, logic [1:0] s);
        case (c)
            0: return curSrc === s;
            1: return pllLocked === 1'b1;
            default: return cpuClkEn === 1'b1;
        endcase
    endfunction

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Phase of the tick against the window allows one count either way
    task automatic chkn(int s, int e);
        check((s > e + 1 || s + 1 < e) ? s : e, e);
    endtask
    task automatic step(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic waitUntil(int c, logic [1:0] s);
        int k;
        for (k = 0; k < 400 && !cond(c, s); k++) begin
            @(posedge core_clk);
            #1;
        end
        if (k == 400) begin
            error_cnt++;
            $display("MISMATCH t=%0t wait limit hit", $time);
            finish_test();
        end
    endtask
    task automatic measure(int n, logic idle, logic [4:0] m, int per);
        int h;
        foreach (cnt[i]) cnt[i] = 0;
        step(n);
        h = expc(cnt[7], dv[1], 1'b1);
        chkn(cnt[7], n / per);
        chkn(cnt[0], idle ? 0 : cnt[7]);
        chkn(cnt[3], idle ? 0 : expc(cnt[7], dv[0], 1'b1));
        chkn(cnt[1], expc(cnt[7], dv[1], m[0]));
        chkn(cnt[2], expc(h, dv[2], m[1]));
        chkn(cnt[4], expc(h, dv[3], m[2]));
        chkn(cnt[5], expc(cnt[7], dv[4], m[3]));
        chkn(cnt[6], (!m[4] || usbSel == 2'h3) ? 0 : (usbSel == 2'h2) ? cnt[9] :
            expc(cnt[7], usbSel[0], 1'b1));
        chkn(cnt[8], cf[1] ? cnt[4] / 2 : 0);
        chkn(cnt[11], cf[2] ? n / 8 : 0);
    endtask
    task automatic toPll();
        cf[0] = 1'b0;
        srcSel = `CGL_SRC_PLL;
        step(1);
        cf[0] = 1'b1;
        waitUntil(1, 2'h0);
        waitUntil(0, `CGL_SRC_PLL);
    endtask

    initial begin
        logic [31:0] r;
        logic [4:0] kept;
        step(4);
        rst_n = 1'b1;
        check(curSrc, `CGL_SRC_OSC);
        check({pllEnable, oscPinEn, inIdle, inSleep}, 4'h4);
        srcSel = `CGL_SRC_PLL;
        step(30);
        check(curSrc, `CGL_SRC_OSC);
        toPll();
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            dv = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : r[4:0];
            cf[3:1] = r[7:5];
            mask = (i < 2) ? 5'h1f : r[12:8];
            usbSel = 2'(i);
            step(6);
            measure(96, 1'b0, mask, 4);
        end
        cf[3] = 1'b1;
        for (int j = 1; j < 4; j++) begin
            sleepSet = 1'b1;
            step(1);
            sleepSet = 1'b0;
            check({inSleep, pllEnable, oscPinEn}, 3'h4);
            foreach (cnt[i]) cnt[i] = 0;
            ev = 5'h10;
            step(40);
            chkn(cnt[10], 2);
            check(inSleep, 1'b1);
            rtcRunning = 1'b0;
            ev = 5'(1 << j);
            step(4);
            check(inSleep, 1'b1);
            rtcRunning = 1'b1;
            step(1);
            check(inSleep, 1'b0);
            ev = 5'h00;
            waitUntil(2, 2'h0);
            check({curSrc, pllEnable}, 3'h0);
        end
        toPll();
        for (int i = 0; i < 5; i++) begin
            r = rnd();
            mask = r[4:0];
            idleSet = 1'b1;
            step(1);
            idleSet = 1'b0;
            kept = mask;
            mask = ~mask;
            check(inIdle, 1'b1);
            measure(64, 1'b1, kept, 4);
            ev[i] = 1'b1;
            step(1);
            ev = 5'h00;
            check({inIdle, inSleep}, 2'h0);
        end
        srcSel = `CGL_SRC_OSC;
        waitUntil(0, `CGL_SRC_OSC);
        cf[0] = 1'b0;
        step(3);
        check({curSrc, pllEnable}, 3'h0);
        srcSel = `CGL_SRC_RTC;
        waitUntil(0, `CGL_SRC_RTC);
        step(4);
        measure(200, 1'b0, mask, 20);
        finish_test();
    end
endmodule

bind cgl_clock_ctrl_unit cgl_clock_ctrl_unit_chk chk_u (.core_clk(core_clk), .rst_n(rst_n),
    .rtcClkIn(rtcClkIn), .rtcOutEnCfg(rtcOutEnCfg), .pllLocked(pllLocked),
    .oscClkIn(oscClkIn), .phyClkEnCfg(phyClkEnCfg), .phyClkOut(phyClkOut),
    .irqPending(irqPending), .rtcAlarm(rtcAlarm), .wakeupIn(wakeupIn),
    .extResetEvt(extResetEvt), .wdogResetEvt(wdogResetEvt), .rtcRunning(rtcRunning),
    .mstrClk(mstrClk), .curSrc(curSrc), .pllEnable(pllEnable), .oscPinEn(oscPinEn),
    .cpuClkEn(cpuClkEn), .hclkEn(hclkEn), .fmiClkEn(fmiClkEn), .usbClkEn(usbClkEn),
    .debugRtcClkOut(debugRtcClkOut), .inIdle(inIdle), .inSleep(inSleep));
`default_nettype wire
